// ===== verilog/pmcs_map.vh
// Summary of operation
// - Regulator on after reset; main in Run, optional low-power in Stop, off in Standby.
// - Sleep stops only the processor clock; any peripheral interrupt or event wakes it.
// - Stop gates all core clocks, PLL and both fast oscillators; memory is kept.
// - Stop wakes on any event line: external lines, detector, RTC, I2C, USART, USB, CEC.
// - In Stop, CEC, USART and I2C may each request the internal RC oscillator.
// - Such a request under low-power regulator first restores normal regulator, then clocks.
// - Standby powers off the core domain, the PLL and every oscillator but the RTC and watchdog clock sources.
// - Standby ends on reset pin, watchdog reset, wakeup pin rising edge or RTC event.
// - RTC, watchdog and their clock sources keep running in Stop and Standby.
// - Every reset selects the internal 8 MHz RC oscillator as processor clock.
// - Selected external clock is monitored; on failure fall back to internal RC, flag it.
// - Internal 48 MHz oscillator selectable as system clock or PLL input, trimmable.
// - Second I/O supply low disables its I/Os and drives event line 31.
// - Enabled supply threshold detector flags falling, rising or both crossings.
// - Device is held in reset while a supply supervisor reports supply too low.
// - Option bit may disable the analog part of the power-down supervisor only.
`ifndef PMCS_MAP_VH
`define PMCS_MAP_VH

`define PMCS_CLK_PERIOD_NS   40
`define PMCS_REG_SETTLE_NS   2000
`define PMCS_REG_SETTLE_CYC  ((`PMCS_REG_SETTLE_NS + `PMCS_CLK_PERIOD_NS - 1) / `PMCS_CLK_PERIOD_NS)
`define PMCS_CSS_TIMEOUT_NS  1000
`define PMCS_CSS_TIMEOUT_CYC (`PMCS_CSS_TIMEOUT_NS / `PMCS_CLK_PERIOD_NS)

`define PMCS_SEL_INT8        2'h0
`define PMCS_SEL_EXT         2'h1
`define PMCS_SEL_PLL         2'h2
`define PMCS_SEL_INT48       2'h3

`define PMCS_TGT_SLEEP       2'h0
`define PMCS_TGT_STOP        2'h1
`define PMCS_TGT_STANDBY     2'h2

`define PMCS_TRIM_RST        6'h20

`endif

// ===== verilog/pmcs_clk_mon.v
`include "pmcs_map.vh"
`default_nettype none

module pmcs_clk_mon
(
    // Clock and reset
    input  wire       clock_in,
    input  wire       external_reset_pin_in,
    // Monitor control
    input  wire       enable_in,
    input  wire       ext_tick_in,
    // Result
    output reg        fail_out
);

    reg  [7:0] gap_r;
    reg        tick_d_r;

    // Any level change on the sampled external clock counts as activity
    always @(posedge clock_in)
    begin
        if (!external_reset_pin_in)
        begin
            gap_r    <= 8'h00;
            tick_d_r <= 1'b0;
            fail_out <= 1'b0;
        end
        else
        begin
            tick_d_r <= ext_tick_in;
            if (!enable_in || (ext_tick_in != tick_d_r))
                gap_r <= 8'h00;
            else if (gap_r != 8'hff)
                gap_r <= gap_r + 8'h01;
            fail_out <= enable_in && ({24'h000000, gap_r} >= `PMCS_CSS_TIMEOUT_CYC);
        end
    end

endmodule // pmcs_clk_mon

`default_nettype wire

// ===== verilog/pmcs_ctrl.v
`include "pmcs_map.vh"
`default_nettype none

module pmcs_ctrl
(
    // Clock and reset
    input  wire        clock_in,
    input  wire        external_reset_pin_in,
    // Supply supervisors
    input  wire        por_low_in,
    input  wire        pdr_main_low_in,
    input  wire        pdr_analog_low_in,
    input  wire        analog_sup_dis_opt_in,
    // Low-power entry control
    input  wire [1:0]  lp_target_in,
    input  wire        stop_lp_reg_in,
    input  wire        wait_instr_in,
    // Wakeup sources
    input  wire        periph_irq_in,
    input  wire [15:0] ext_event_lines_in,
    input  wire        rtc_event_in,
    input  wire        i2c_wake_in,
    input  wire        usart_wake_in,
    input  wire        usb_wake_in,
    input  wire        cec_wake_in,
    input  wire        external_reset_pin_low_in,
    input  wire        watchdog_reset_in,
    input  wire        wakeup_pin_in,
    // Oscillator requests in Stop
    input  wire        cec_osc_req_in,
    input  wire        usart_osc_req_in,
    input  wire        i2c_osc_req_in,
    // Clock selection
    input  wire        sysclk_req_in,
    input  wire [1:0]  sysclk_sel_in,
    input  wire        pll_src_int48_in,
    input  wire        ext_osc_en_in,
    input  wire        ext_clk_tick_in,
    input  wire        clk_fail_irq_en_in,
    input  wire        trim_en_in,
    input  wire        trim_up_in,
    input  wire        trim_dn_in,
    // Supply monitors
    input  wire        io2_supply_low_in,
    input  wire        detector_en_in,
    input  wire        detector_fall_en_in,
    input  wire        detector_rise_en_in,
    input  wire        supply_below_in,
    // Reset and power outputs
    output reg         sys_reset_out,
    output reg         reg_enable_out,
    output reg         reg_lowpower_out,
    output reg         reg_hiz_out,
    output reg         core_power_on_out,
    output reg         sram_retain_out,
    // Clock gating outputs
    output reg         cpu_clk_en_out,
    output reg         periph_clk_en_out,
    output reg         pll_en_out,
    output reg         int_osc_en_out,
    output reg         int48_osc_en_out,
    output reg         ext_osc_en_out,
    output reg         rtc_wdg_clk_en_out,
    output reg         cec_osc_grant_out,
    output reg         usart_osc_grant_out,
    output reg         i2c_osc_grant_out,
    // Clock selection outputs
    output reg  [1:0]  sysclk_sel_out,
    output reg         pll_src_int48_out,
    output reg  [5:0]  int48_trim_out,
    output reg         clk_fail_irq_out,
    // Monitor outputs
    output reg         io2_disable_out,
    output reg         event_line31_out,
    output reg         detector_irq_out,
    output reg  [1:0]  pwr_state_out
);

    localparam ST_RUN     = 3'h0;
    localparam ST_SLEEP   = 3'h1;
    localparam ST_STOP    = 3'h2;
    localparam ST_BOOST   = 3'h3;
    localparam ST_STANDBY = 3'h4;
    localparam ST_EXIT    = 3'h5;

    reg  [2:0] state_r;
    reg  [2:0] state_nxt;
    reg  [7:0] settle_r;
    reg        lp_reg_r;
    reg        wakeup_pin_d_r;
    reg        below_d_r;
    reg  [2:0] req_hold_r;
    wire       sup_hold;
    wire       rst_any;
    wire       stop_wake;
    wire       standby_wake;
    wire       wakeup_pin_rise;
    wire       det_fall;
    wire       det_rise;
    wire [2:0] osc_req;
    wire       clk_fail;
    wire       grant_ok;

    // Analog-rail supervisor can be masked by the option bit, main rail never
    assign sup_hold = por_low_in | pdr_main_low_in
                    | (pdr_analog_low_in & ~analog_sup_dis_opt_in);
    assign rst_any  = ~external_reset_pin_in | sup_hold;

    assign wakeup_pin_rise = wakeup_pin_in & ~wakeup_pin_d_r;
    assign det_fall  = detector_en_in & supply_below_in & ~below_d_r;
    assign det_rise  = detector_en_in & ~supply_below_in & below_d_r;
    assign osc_req   = {cec_osc_req_in, usart_osc_req_in, i2c_osc_req_in};

    // Detector output and event line 31 are event sources as well
    assign stop_wake = (|ext_event_lines_in) | det_fall | det_rise | io2_supply_low_in
                     | rtc_event_in | i2c_wake_in | usart_wake_in
                     | usb_wake_in | cec_wake_in;
    assign standby_wake = external_reset_pin_low_in | watchdog_reset_in
                        | wakeup_pin_rise | rtc_event_in;

    // Grants: direct when regulator already normal, after settling otherwise
    assign grant_ok = (state_r == ST_STOP && state_nxt == ST_STOP && !lp_reg_r)
                    || (state_r == ST_BOOST && state_nxt == ST_BOOST
                        && {24'h000000, settle_r} == `PMCS_REG_SETTLE_CYC);

    pmcs_clk_mon u_clk_mon
    (
        .clock_in    (clock_in),
        .external_reset_pin_in     (~rst_any),
        .enable_in   (sysclk_sel_out == `PMCS_SEL_EXT),
        .ext_tick_in (ext_clk_tick_in),
        .fail_out    (clk_fail)
    );

    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN:
                if (wait_instr_in)
                begin
                    if (lp_target_in == `PMCS_TGT_STOP)
                        state_nxt = ST_STOP;
                    else if (lp_target_in == `PMCS_TGT_STANDBY)
                        state_nxt = ST_STANDBY;
                    else
                        state_nxt = ST_SLEEP;
                end
            ST_SLEEP:
                if (periph_irq_in || stop_wake)
                    state_nxt = ST_RUN;
            ST_STOP:
                if (stop_wake)
                    state_nxt = ST_RUN;
                else if ((|osc_req) && lp_reg_r)
                    state_nxt = ST_BOOST;
            ST_BOOST:
                if (stop_wake)
                    state_nxt = ST_RUN;
                else if (!(|osc_req) && (req_hold_r == 3'h0))
                    state_nxt = ST_STOP;
            ST_STANDBY:
                if (standby_wake)
                    state_nxt = ST_EXIT;
            default:
                state_nxt = ST_RUN;
        endcase
    end

    always @(posedge clock_in)
    begin
        if (rst_any)
        begin
            state_r    <= ST_RUN;
            settle_r   <= 8'h00;
            lp_reg_r   <= 1'b0;
            wakeup_pin_d_r   <= 1'b0;
            below_d_r  <= 1'b0;
            req_hold_r <= 3'h0;
        end
        else
        begin
            state_r   <= state_nxt;
            wakeup_pin_d_r  <= wakeup_pin_in;
            below_d_r <= supply_below_in;
            if (state_r == ST_RUN && wait_instr_in)
                lp_reg_r <= stop_lp_reg_in;
            // Regulator must settle in normal mode before any clock is released
            if (state_r == ST_BOOST)
            begin
                if ({24'h000000, settle_r} != `PMCS_REG_SETTLE_CYC)
                    settle_r <= settle_r + 8'h01;
            end
            else
                settle_r <= 8'h00;
            req_hold_r <= (state_r == ST_STOP || state_r == ST_BOOST) ? osc_req : 3'h0;
        end
    end

    // Power, regulator and gating outputs
    always @(posedge clock_in)
    begin
        if (rst_any)
        begin
            reg_enable_out      <= 1'b1;
            reg_lowpower_out    <= 1'b0;
            reg_hiz_out         <= 1'b0;
            core_power_on_out   <= 1'b1;
            sram_retain_out     <= 1'b1;
            cpu_clk_en_out      <= 1'b1;
            periph_clk_en_out   <= 1'b1;
            pll_en_out          <= 1'b0;
            int_osc_en_out      <= 1'b1;
            ext_osc_en_out      <= 1'b0;
            rtc_wdg_clk_en_out  <= 1'b1;
            cec_osc_grant_out   <= 1'b0;
            usart_osc_grant_out <= 1'b0;
            i2c_osc_grant_out   <= 1'b0;
            pwr_state_out       <= 2'h0;
        end
        else
        begin
            rtc_wdg_clk_en_out <= 1'b1;
            case (state_nxt)
                ST_STOP, ST_BOOST:
                begin
                    reg_enable_out    <= 1'b1;
                    // Boost keeps the main regulator until requests drop
                    reg_lowpower_out  <= (state_r == ST_RUN ? stop_lp_reg_in : lp_reg_r)
                                      && (state_nxt == ST_STOP);
                    reg_hiz_out       <= 1'b0;
                    core_power_on_out <= 1'b1;
                    sram_retain_out   <= 1'b1;
                    cpu_clk_en_out    <= 1'b0;
                    periph_clk_en_out <= 1'b0;
                    pll_en_out        <= 1'b0;
                    ext_osc_en_out    <= 1'b0;
                    int_osc_en_out    <= grant_ok && (|osc_req);
                    pwr_state_out     <= 2'h2;
                end
                ST_STANDBY:
                begin
                    reg_enable_out    <= 1'b0;
                    reg_lowpower_out  <= 1'b0;
                    reg_hiz_out       <= 1'b1;
                    core_power_on_out <= 1'b0;
                    sram_retain_out   <= 1'b0;
                    cpu_clk_en_out    <= 1'b0;
                    periph_clk_en_out <= 1'b0;
                    pll_en_out        <= 1'b0;
                    int_osc_en_out    <= 1'b0;
                    ext_osc_en_out    <= 1'b0;
                    pwr_state_out     <= 2'h3;
                end
                default:
                begin
                    reg_enable_out    <= 1'b1;
                    reg_lowpower_out  <= 1'b0;
                    reg_hiz_out       <= 1'b0;
                    core_power_on_out <= 1'b1;
                    sram_retain_out   <= 1'b1;
                    cpu_clk_en_out    <= (state_nxt != ST_SLEEP);
                    periph_clk_en_out <= 1'b1;
                    pll_en_out        <= (sysclk_sel_out == `PMCS_SEL_PLL);
                    int_osc_en_out    <= 1'b1;
                    ext_osc_en_out    <= ext_osc_en_in;
                    pwr_state_out     <= {1'b0, (state_nxt == ST_SLEEP)};
                end
            endcase
            cec_osc_grant_out   <= grant_ok && cec_osc_req_in;
            usart_osc_grant_out <= grant_ok && usart_osc_req_in;
            i2c_osc_grant_out   <= grant_ok && i2c_osc_req_in;
        end
    end

    // Clock selection, fallback and trim
    always @(posedge clock_in)
    begin
        if (rst_any)
        begin
            sysclk_sel_out    <= `PMCS_SEL_INT8;
            pll_src_int48_out <= 1'b0;
            int48_osc_en_out  <= 1'b0;
            int48_trim_out    <= `PMCS_TRIM_RST;
            clk_fail_irq_out  <= 1'b0;
            sys_reset_out     <= 1'b1;
        end
        else
        begin
            // Standby exit restarts the core like a reset
            sys_reset_out    <= (state_nxt == ST_EXIT);
            clk_fail_irq_out <= clk_fail && clk_fail_irq_en_in
                             && (sysclk_sel_out == `PMCS_SEL_EXT);
            if (state_nxt == ST_EXIT)
                sysclk_sel_out <= `PMCS_SEL_INT8;
            else if (clk_fail && sysclk_sel_out == `PMCS_SEL_EXT)
                sysclk_sel_out <= `PMCS_SEL_INT8;
            else if (sysclk_req_in)
                sysclk_sel_out <= sysclk_sel_in;
            if (state_nxt == ST_EXIT)
                pll_src_int48_out <= 1'b0;
            else if (sysclk_req_in)
                pll_src_int48_out <= pll_src_int48_in;
            // Fast oscillators are off in Stop and Standby
            int48_osc_en_out <= (state_nxt == ST_RUN || state_nxt == ST_SLEEP)
                             && (sysclk_sel_out == `PMCS_SEL_INT48
                                 || pll_src_int48_out);
            if (trim_en_in && trim_up_in && !trim_dn_in && int48_trim_out != 6'h3f)
                int48_trim_out <= int48_trim_out + 6'h01;
            else if (trim_en_in && trim_dn_in && !trim_up_in && int48_trim_out != 6'h00)
                int48_trim_out <= int48_trim_out - 6'h01;
        end
    end

    // Supply monitors keep working in every power state
    always @(posedge clock_in)
    begin
        if (rst_any)
        begin
            io2_disable_out  <= 1'b0;
            event_line31_out <= 1'b0;
            detector_irq_out <= 1'b0;
        end
        else
        begin
            io2_disable_out  <= io2_supply_low_in;
            event_line31_out <= io2_supply_low_in;
            detector_irq_out <= (det_fall && detector_fall_en_in)
                             || (det_rise && detector_rise_en_in);
        end
    end

endmodule // pmcs_ctrl

`default_nettype wire

// ===== verilog/pmcs_ctrl_end.v
`default_nettype none
`default_nettype wire

// ===== tb/pmcs_ctrl_properties.sv
`default_nettype none
module pmcs_ctrl_chk
(
    // Clock, reset and supervisors
    input wire logic       clock_in,
    input wire logic       external_reset_pin_in,
    input wire logic       por_low_in,
    input wire logic       pdr_main_low_in,
    input wire logic       pdr_analog_low_in,
    input wire logic       analog_sup_dis_opt_in,
    // Watched inputs
    input wire logic       ext_clk_tick_in,
    input wire logic       io2_supply_low_in,
    input wire logic       detector_en_in,
    // Power and clock outputs
    input wire logic       sys_reset_out,
    input wire logic       reg_enable_out,
    input wire logic       reg_lowpower_out,
    input wire logic       reg_hiz_out,
    input wire logic       core_power_on_out,
    input wire logic       sram_retain_out,
    input wire logic       cpu_clk_en_out,
    input wire logic       periph_clk_en_out,
    input wire logic       pll_en_out,
    input wire logic       int_osc_en_out,
    input wire logic       ext_osc_en_out,
    input wire logic       rtc_wdg_clk_en_out,
    input wire logic       cec_osc_grant_out,
    input wire logic       usart_osc_grant_out,
    input wire logic       i2c_osc_grant_out,
    input wire logic [1:0] sysclk_sel_out,
    // Monitor outputs
    input wire logic       io2_disable_out,
    input wire logic       event_line31_out,
    input wire logic       detector_irq_out,
    input wire logic [1:0] pwr_state_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       sup_hold;
    logic       any_grant;
    logic       tick_q_r;
    logic [7:0] quiet_r;

    default clocking dcb @(posedge clock_in); endclocking
    default disable iff (!external_reset_pin_in);

    assign sup_hold  = por_low_in | pdr_main_low_in | (pdr_analog_low_in & ~analog_sup_dis_opt_in);
    assign any_grant = cec_osc_grant_out | usart_osc_grant_out | i2c_osc_grant_out;

    // A dead external clock left selected means the fallback never fired
    always_ff @(posedge clock_in)
    begin
        tick_q_r <= ext_clk_tick_in;
        if (!external_reset_pin_in || sysclk_sel_out != 2'h1 || ext_clk_tick_in != tick_q_r)
            quiet_r <= 8'h00;
        else if (quiet_r != 8'hff)
            quiet_r <= quiet_r + 8'h01;
    end

    AST_SUP_HOLD: assert property (sup_hold |=> sys_reset_out)
        else $error("supervisor low did not hold reset");
    AST_RUN_MAIN: assert property (pwr_state_out == 2'h0 && !sys_reset_out |->
        reg_enable_out && !reg_lowpower_out && !reg_hiz_out && core_power_on_out)
        else $error("run without main regulator");
    AST_STANDBY_OFF: assert property (pwr_state_out == 2'h3 |-> !reg_enable_out &&
        reg_hiz_out && !core_power_on_out && !pll_en_out && !int_osc_en_out && !ext_osc_en_out)
        else $error("standby left power or oscillators on");
    AST_SLEEP_CLK: assert property (pwr_state_out == 2'h1 |-> !cpu_clk_en_out && periph_clk_en_out)
        else $error("sleep clock gating wrong");
    AST_STOP_CLK: assert property (pwr_state_out == 2'h2 |-> !cpu_clk_en_out && !pll_en_out &&
        !ext_osc_en_out && sram_retain_out)
        else $error("stop clock gating wrong");
    AST_GRANT_MAIN: assert property (any_grant |-> !reg_lowpower_out)
        else $error("oscillator granted under low-power regulator");
    AST_RTC_ON: assert property (rtc_wdg_clk_en_out)
        else $error("rtc and watchdog clock stopped");
    AST_RESET_INT8: assert property (sys_reset_out |-> sysclk_sel_out == 2'h0)
        else $error("reset without internal 8 MHz clock");
    AST_IO2_FOLLOW: assert property (!sup_hold && !sys_reset_out |=>
        io2_disable_out == $past(io2_supply_low_in) && event_line31_out == $past(io2_supply_low_in))
        else $error("io2 disable or event line 31 wrong");
    AST_DET_PULSE: assert property (detector_irq_out |-> $past(detector_en_in) ##1 !detector_irq_out)
        else $error("detector irq not a single enabled pulse");
    AST_FALLBACK: assert property (quiet_r <= 8'h20)
        else $error("dead external clock still selected");
endmodule // pmcs_ctrl_chk

bind pmcs_ctrl pmcs_ctrl_chk i_chk (.*);
`default_nettype wire

// ===== tb/tb.sv
`include "pmcs_map.vh"
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        num_checks++; \
        if ((g) !== (e)) \
        begin \
            n_mismatch++; \
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
        end \
    end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_in = 1'b0;
    logic        external_reset_pin_in, por_low_in, pdr_main_low_in, pdr_analog_low_in, analog_sup_dis_opt_in;
    logic        stop_lp_reg_in, wait_instr_in, periph_irq_in, rtc_event_in, i2c_wake_in;
    logic        usart_wake_in, usb_wake_in, cec_wake_in, external_reset_pin_low_in;
    logic        watchdog_reset_in, wakeup_pin_in, cec_osc_req_in, usart_osc_req_in;
    logic        i2c_osc_req_in, sysclk_req_in, pll_src_int48_in, ext_osc_en_in;
    logic        clk_fail_irq_en_in, trim_en_in, trim_up_in, trim_dn_in;
    logic        io2_supply_low_in, detector_en_in, detector_fall_en_in;
    logic        detector_rise_en_in, supply_below_in;
    logic [1:0]  lp_target_in, sysclk_sel_in, sysclk_sel_out, pwr_state_out;
    logic [15:0] ext_event_lines_in;
    logic        sys_reset_out, reg_enable_out, reg_lowpower_out, reg_hiz_out;
    logic        core_power_on_out, sram_retain_out, cpu_clk_en_out, periph_clk_en_out;
    logic        pll_en_out, int_osc_en_out, int48_osc_en_out, ext_osc_en_out;
    logic        rtc_wdg_clk_en_out, cec_osc_grant_out, usart_osc_grant_out, i2c_osc_grant_out;
    logic        pll_src_int48_out, clk_fail_irq_out, io2_disable_out, event_line31_out;
    logic        detector_irq_out;
    logic [5:0]  int48_trim_out;
    logic        tick_run = 1'b0;
    logic        ext_clk_tick_in = 1'b0;
    logic        seen;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          k;

    pmcs_ctrl i_dut (.*);

    always #20 clock_in = ~clock_in;
    // External clock runs only while a test wants it
    always @(negedge clock_in)
        if (tick_run)
            ext_clk_tick_in <= ~ext_clk_tick_in;

    task automatic cyc(input int n);
        repeat (n) @(negedge clock_in);
    endtask

    task automatic enter(input logic [1:0] t, input logic lp);
        lp_target_in   = t;
        stop_lp_reg_in = lp;
        wait_instr_in  = 1'b1;
        cyc(1);
        wait_instr_in  = 1'b0;
        cyc(2);
    endtask

    task automatic sel_clk(input logic [1:0] s, input logic p);
        sysclk_sel_in    = s;
        pll_src_int48_in = p;
        sysclk_req_in    = 1'b1;
        cyc(1);
        sysclk_req_in    = 1'b0;
        cyc(2);
    endtask

    task automatic src(input int i, input logic v);
        case (i)
            0: ext_event_lines_in[0] = v;
            1: ext_event_lines_in[15] = v;
            2: rtc_event_in = v;
            3: i2c_wake_in = v;
            4: usart_wake_in = v;
            5: usb_wake_in = v;
            6: cec_wake_in = v;
            7: wakeup_pin_in = v;
            8: watchdog_reset_in = v;
            default: external_reset_pin_low_in = v;
        endcase
    endtask

    task automatic wake(input int i);
        src(i, 1'b1);
        cyc(3);
        src(i, 1'b0);
    endtask

    task automatic trim(input logic u, input logic d);
        trim_up_in = u;
        trim_dn_in = d;
        trim_en_in = 1'b1;
        cyc(1);
        trim_en_in = 1'b0;
        cyc(1);
    endtask

    task automatic det(input logic v, input int e);
        int c = 0;
        supply_below_in = v;
        repeat (5)
        begin
            cyc(1);
            c += (detector_irq_out === 1'b1);
        end
        `CHK("detector pulses", e, c)
    endtask

    task automatic sup(input logic [3:0] v, input logic e);
        {por_low_in, pdr_main_low_in, pdr_analog_low_in, analog_sup_dis_opt_in} = v;
        cyc(2);
        `CHK("supervisor reset", e, sys_reset_out)
        {por_low_in, pdr_main_low_in, pdr_analog_low_in, analog_sup_dis_opt_in} = 4'h0;
        cyc(3);
    endtask

    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        {external_reset_pin_in, por_low_in, pdr_main_low_in, pdr_analog_low_in, analog_sup_dis_opt_in,
         stop_lp_reg_in, wait_instr_in, periph_irq_in, rtc_event_in, i2c_wake_in,
         usart_wake_in, usb_wake_in, cec_wake_in, external_reset_pin_low_in,
         watchdog_reset_in, wakeup_pin_in, cec_osc_req_in, usart_osc_req_in,
         i2c_osc_req_in, sysclk_req_in, pll_src_int48_in, ext_osc_en_in,
         clk_fail_irq_en_in, trim_en_in, trim_up_in, trim_dn_in,
         io2_supply_low_in, detector_en_in, detector_fall_en_in,
         detector_rise_en_in, supply_below_in, lp_target_in, sysclk_sel_in,
         ext_event_lines_in} = '0;
        cyc(2);
        external_reset_pin_in = 1'b1;
        cyc(2);
        `CHK("reset out", 1'b0, sys_reset_out)
        `CHK("regulator on", 1'b1, reg_enable_out)
        `CHK("clock select", 2'h0, sysclk_sel_out)
        `CHK("trim", `PMCS_TRIM_RST, int48_trim_out)
        enter(2'h0, 1'b0);
        `CHK("sleep cpu clock", 1'b0, cpu_clk_en_out)
        `CHK("sleep periph clock", 1'b1, periph_clk_en_out)
        periph_irq_in = 1'b1;
        cyc(3);
        periph_irq_in = 1'b0;
        `CHK("sleep wake", 2'h0, pwr_state_out)
        for (k = 0; k < 7; k++)
        begin
            enter(2'h1, k[0]);
            `CHK("stop state", 2'h2, pwr_state_out)
            `CHK("stop periph clock", 1'b0, periph_clk_en_out)
            `CHK("stop int osc", 1'b0, int_osc_en_out)
            `CHK("stop lp reg", k[0], reg_lowpower_out)
            wake(k);
            `CHK("stop wake", 2'h0, pwr_state_out)
        end
        enter(2'h1, 1'b1);
        cec_osc_req_in = 1'b1;
        k = 0;
        while (cec_osc_grant_out !== 1'b1 && k < 100)
        begin
            cyc(1);
            k++;
        end
        `CHK("grant wait", 1'b1, k >= `PMCS_REG_SETTLE_CYC && k < 100)
        `CHK("grant main reg", 1'b0, reg_lowpower_out)
        `CHK("grant osc on", 1'b1, int_osc_en_out)
        cec_osc_req_in = 1'b0;
        cyc(4);
        `CHK("grant drop", 1'b0, cec_osc_grant_out)
        `CHK("lp reg back", 1'b1, reg_lowpower_out)
        wake(2);
        enter(2'h1, 1'b0);
        usart_osc_req_in = 1'b1;
        i2c_osc_req_in = 1'b1;
        cyc(2);
        `CHK("usart grant", 1'b1, usart_osc_grant_out)
        `CHK("i2c grant", 1'b1, i2c_osc_grant_out)
        usart_osc_req_in = 1'b0;
        i2c_osc_req_in = 1'b0;
        wake(5);
        for (k = 0; k < 4; k++)
        begin
            sel_clk(2'h2, 1'b0);
            enter(2'h2, 1'b0);
            `CHK("standby hiz", 1'b1, reg_hiz_out)
            `CHK("standby core off", 1'b0, core_power_on_out)
            `CHK("standby rtc clock", 1'b1, rtc_wdg_clk_en_out)
            wake(0);
            `CHK("standby ignores line", 2'h3, pwr_state_out)
            seen = 1'b0;
            src(k == 0 ? 2 : k + 6, 1'b1);
            repeat (12)
            begin
                cyc(1);
                src(k == 0 ? 2 : k + 6, 1'b0);
                seen |= (sys_reset_out === 1'b1);
            end
            `CHK("standby exit reset", 1'b1, seen)
            `CHK("standby exit run", 2'h0, pwr_state_out)
            `CHK("exit clock int8", 2'h0, sysclk_sel_out)
        end
        ext_osc_en_in = 1'b1;
        clk_fail_irq_en_in = 1'b1;
        tick_run = 1'b1;
        sel_clk(2'h1, 1'b0);
        cyc(40);
        `CHK("ext kept alive", 2'h1, sysclk_sel_out)
        tick_run = 1'b0;
        seen = 1'b0;
        repeat (40)
        begin
            cyc(1);
            seen |= (clk_fail_irq_out === 1'b1);
        end
        `CHK("fail irq", 1'b1, seen)
        `CHK("fallback int8", 2'h0, sysclk_sel_out)
        trim(1'b1, 1'b0);
        trim(1'b1, 1'b0);
        trim(1'b0, 1'b1);
        trim(1'b1, 1'b1);
        `CHK("trim steps", 6'h21, int48_trim_out)
        sel_clk(2'h3, 1'b1);
        `CHK("int48 select", 2'h3, sysclk_sel_out)
        `CHK("pll from int48", 1'b1, pll_src_int48_out)
        `CHK("int48 osc on", 1'b1, int48_osc_en_out)
        io2_supply_low_in = 1'b1;
        cyc(2);
        `CHK("io2 disable", 1'b1, io2_disable_out)
        `CHK("event line 31", 1'b1, event_line31_out)
        io2_supply_low_in = 1'b0;
        detector_en_in = 1'b1;
        detector_fall_en_in = 1'b1;
        det(1'b1, 1);
        det(1'b0, 0);
        detector_rise_en_in = 1'b1;
        det(1'b1, 1);
        det(1'b0, 1);
        detector_en_in = 1'b0;
        det(1'b1, 0);
        sup(4'h8, 1'b1);
        sup(4'h4, 1'b1);
        sup(4'h2, 1'b1);
        sup(4'h3, 1'b0);
        report_and_stop();
    end

    // Tests need about 350 cycles
    initial
    begin
        #(40 * 5000);
        n_mismatch++;
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
